// ===== verilog/bififo_params.svh
// Constants of the bidirectional queue port-B and flag block.
// Assumes inclusion by bare name from the design module only.
`ifndef BIFIFO_PARAMS_SVH
`define BIFIFO_PARAMS_SVH

// Port A resource addresses
`define RES_QUEUE 3'h0
`define RES_BYPASS 3'h1
`define RES_PAE_AB 3'h2
`define RES_PAF_AB 3'h3
`define RES_PAE_BA 3'h4
`define RES_PAF_BA 3'h5
`define RES_CONTROL 3'h6
`define RES_STATUS 3'h7

// Control word field
`define CTRL_BYPASS_BIT 0

// Reset value of every offset register
`define OFFSET_DEFAULT 'h8

// Default geometry
`define QUEUE_DEPTH 256
`define WORD_WIDTH 18

`endif

// ===== verilog/bififo_types_pkg.sv
// Types shared by the bidirectional queue block.
// Assumes nothing of its surroundings.
package bififo_types_pkg;

  // Port B operation decode, Gray ordered idle -> write -> read
  typedef enum logic [1:0]
  {
    OP_IDLE = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h3
  } port_op_t;

endpackage : bififo_types_pkg

// ===== verilog/bififo_port_b_flags.sv
// Bidirectional queue pair with port B control, status flags and bypass path.
// Assumes both ports and the flag readers run on clk; port A is a plain register-style port.
`include "bififo_params.svh"

////////////////////////////////////////////////////////////////////////////////
module bififo_port_b_flags #(
  parameter int DEPTH = `QUEUE_DEPTH,
  parameter int WIDTH = `WORD_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic port_a_select_n,
  input wire logic [2:0] port_a_resource_addr,
  input wire logic port_a_write_strobe,
  input wire logic port_a_read_strobe,
  input wire logic [WIDTH-1:0] port_a_write_data,
  output logic [WIDTH-1:0] port_a_read_data,
  input wire logic port_b_direction_select,
  input wire logic port_b_transfer_enable_n,
  input wire logic port_b_output_enable_n,
  input wire logic [WIDTH-1:0] port_b_data_in,
  output logic [WIDTH-1:0] port_b_data_out,
  output logic port_b_data_oe,
  output logic a_to_b_empty_n,
  output logic a_to_b_almost_empty_n,
  output logic a_to_b_almost_full_n,
  output logic a_to_b_full_n,
  output logic b_to_a_empty_n,
  output logic b_to_a_almost_empty_n,
  output logic b_to_a_almost_full_n,
  output logic b_to_a_full_n,
  output logic bypass_indicator_n
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] OFF_DEF = CW'(`OFFSET_DEFAULT);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [WIDTH-1:0] mem_ab [DEPTH];
  logic [WIDTH-1:0] mem_ba [DEPTH];
  logic [AW-1:0] ab_wp_reg, ab_rp_reg, ba_wp_reg, ba_rp_reg;
  logic [CW-1:0] ab_cnt_reg, ba_cnt_reg, ab_cnt_next, ba_cnt_next;
  logic [CW-1:0] pae_ab_reg, paf_ab_reg, pae_ba_reg, paf_ba_reg;
  logic bypass_reg;
  logic [WIDTH-1:0] ab_msg_reg, ba_msg_reg;
  logic ab_msg_full_reg, ba_msg_full_reg, ab_msg_full_next, ba_msg_full_next;
  logic [WIDTH-1:0] a_rdata_reg, b_dout_reg;
  logic b_oe_reg;
  logic ab_e_reg, ab_ae_reg, ab_af_reg, ab_f_reg;
  logic ba_e_reg, ba_ae_reg, ba_af_reg, ba_f_reg;
  logic byp_n_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Access decode

  bififo_types_pkg::port_op_t b_op;
  logic a_wr, a_rd;
  logic ab_push, ab_pop, ba_push, ba_pop;
  logic ab_msg_wr, ab_msg_rd, ba_msg_wr, ba_msg_rd;

  always_comb
  begin
    if (port_b_transfer_enable_n)
      b_op = bififo_types_pkg::OP_IDLE;
    else if (port_b_direction_select)
      b_op = bififo_types_pkg::OP_READ;
    else
      b_op = bififo_types_pkg::OP_WRITE;
  end

  assign a_wr = !port_a_select_n && port_a_write_strobe;
  assign a_rd = !port_a_select_n && port_a_read_strobe;

  // Counts guard the queues, so a stale flag can never cause overrun
  assign ab_push = a_wr && port_a_resource_addr == `RES_QUEUE && !bypass_reg && ab_cnt_reg != DEPTH_C;
  assign ab_pop = b_op == bififo_types_pkg::OP_READ && !bypass_reg && ab_cnt_reg != '0;
  assign ba_push = b_op == bififo_types_pkg::OP_WRITE && !bypass_reg && ba_cnt_reg != DEPTH_C;
  assign ba_pop = a_rd && port_a_resource_addr == `RES_QUEUE && !bypass_reg && ba_cnt_reg != '0;

  // One message per direction in bypass; a full message register refuses the writer
  assign ab_msg_wr = a_wr && port_a_resource_addr == `RES_BYPASS && bypass_reg && !ab_msg_full_reg;
  assign ab_msg_rd = b_op == bififo_types_pkg::OP_READ && bypass_reg && ab_msg_full_reg;
  assign ba_msg_wr = b_op == bififo_types_pkg::OP_WRITE && bypass_reg && !ba_msg_full_reg;
  assign ba_msg_rd = a_rd && port_a_resource_addr == `RES_BYPASS && bypass_reg && ba_msg_full_reg;

  assign ab_cnt_next = ab_cnt_reg + CW'(ab_push) - CW'(ab_pop);
  assign ba_cnt_next = ba_cnt_reg + CW'(ba_push) - CW'(ba_pop);
  // Set wins over clear, though the guards above keep them apart
  assign ab_msg_full_next = ab_msg_wr || (ab_msg_full_reg && !ab_msg_rd);
  assign ba_msg_full_next = ba_msg_wr || (ba_msg_full_reg && !ba_msg_rd);

  ////////////////////////////////////////////////////////////////////////////////
  // Queues

  always_ff @(posedge clk)
  begin
    if (ab_push)
      mem_ab[ab_wp_reg] <= port_a_write_data;
    if (ba_push)
      mem_ba[ba_wp_reg] <= port_b_data_in;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ab_wp_reg <= '0;
      ab_rp_reg <= '0;
      ba_wp_reg <= '0;
      ba_rp_reg <= '0;
      ab_cnt_reg <= '0;
      ba_cnt_reg <= '0;
    end
    else
    begin
      ab_wp_reg <= ab_wp_reg + AW'(ab_push);
      ab_rp_reg <= ab_rp_reg + AW'(ab_pop);
      ba_wp_reg <= ba_wp_reg + AW'(ba_push);
      ba_rp_reg <= ba_rp_reg + AW'(ba_pop);
      ab_cnt_reg <= ab_cnt_next;
      ba_cnt_reg <= ba_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port A resources: offsets, mode and bypass messages

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pae_ab_reg <= OFF_DEF;
      paf_ab_reg <= OFF_DEF;
      pae_ba_reg <= OFF_DEF;
      paf_ba_reg <= OFF_DEF;
      bypass_reg <= 1'b0;
    end
    else if (a_wr)
    begin
      case (port_a_resource_addr)
        `RES_PAE_AB: pae_ab_reg <= CW'(port_a_write_data);
        `RES_PAF_AB: paf_ab_reg <= CW'(port_a_write_data);
        `RES_PAE_BA: pae_ba_reg <= CW'(port_a_write_data);
        `RES_PAF_BA: paf_ba_reg <= CW'(port_a_write_data);
        `RES_CONTROL: bypass_reg <= port_a_write_data[`CTRL_BYPASS_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ab_msg_reg <= '0;
      ba_msg_reg <= '0;
      ab_msg_full_reg <= 1'b0;
      ba_msg_full_reg <= 1'b0;
    end
    else
    begin
      if (ab_msg_wr)
        ab_msg_reg <= port_a_write_data;
      if (ba_msg_wr)
        ba_msg_reg <= port_b_data_in;
      ab_msg_full_reg <= ab_msg_full_next;
      ba_msg_full_reg <= ba_msg_full_next;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      a_rdata_reg <= '0;
    else if (a_rd)
    begin
      case (port_a_resource_addr)
        `RES_QUEUE: a_rdata_reg <= ba_pop ? mem_ba[ba_rp_reg] : '0;
        `RES_BYPASS: a_rdata_reg <= ba_msg_rd ? ba_msg_reg : '0;
        `RES_PAE_AB: a_rdata_reg <= WIDTH'(pae_ab_reg);
        `RES_PAF_AB: a_rdata_reg <= WIDTH'(paf_ab_reg);
        `RES_PAE_BA: a_rdata_reg <= WIDTH'(pae_ba_reg);
        `RES_PAF_BA: a_rdata_reg <= WIDTH'(paf_ba_reg);
        `RES_CONTROL: a_rdata_reg <= WIDTH'(bypass_reg);
        default: a_rdata_reg <= WIDTH'({ab_e_reg, ab_ae_reg, ab_af_reg, ab_f_reg,
                                        ba_e_reg, ba_ae_reg, ba_af_reg, ba_f_reg});
      endcase
    end
    else
      a_rdata_reg <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port B data path

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      b_dout_reg <= '0;
      b_oe_reg <= 1'b0;
    end
    else
    begin
      if (ab_pop)
        b_dout_reg <= mem_ab[ab_rp_reg];
      else if (ab_msg_rd)
        b_dout_reg <= ab_msg_reg;
      // Enable is registered, so the bus turns one cycle after the pins ask
      b_oe_reg <= port_b_direction_select && !port_b_output_enable_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags from next state so they agree with the counts; the bypass indicator follows bypass_reg one edge later

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ab_e_reg <= 1'b0;
      ab_ae_reg <= 1'b0;
      ab_af_reg <= 1'b1;
      ab_f_reg <= 1'b1;
      ba_e_reg <= 1'b0;
      ba_ae_reg <= 1'b0;
      ba_af_reg <= 1'b1;
      ba_f_reg <= 1'b1;
      byp_n_reg <= 1'b1;
    end
    else
    begin
      ab_e_reg <= bypass_reg ? ab_msg_full_next : ab_cnt_next != '0;
      ab_f_reg <= bypass_reg ? !ab_msg_full_next : ab_cnt_next != DEPTH_C;
      ba_e_reg <= bypass_reg ? ba_msg_full_next : ba_cnt_next != '0;
      ba_f_reg <= bypass_reg ? !ba_msg_full_next : ba_cnt_next != DEPTH_C;
      ab_ae_reg <= ab_cnt_next > pae_ab_reg;
      ba_ae_reg <= ba_cnt_next > pae_ba_reg;
      ab_af_reg <= ab_cnt_next <= DEPTH_C - paf_ab_reg;
      ba_af_reg <= ba_cnt_next <= DEPTH_C - paf_ba_reg;
      byp_n_reg <= !bypass_reg;
    end
  end

  assign port_a_read_data = a_rdata_reg;
  assign port_b_data_out = b_dout_reg;
  assign port_b_data_oe = b_oe_reg;
  assign a_to_b_empty_n = ab_e_reg;
  assign a_to_b_almost_empty_n = ab_ae_reg;
  assign a_to_b_almost_full_n = ab_af_reg;
  assign a_to_b_full_n = ab_f_reg;
  assign b_to_a_empty_n = ba_e_reg;
  assign b_to_a_almost_empty_n = ba_ae_reg;
  assign b_to_a_almost_full_n = ba_af_reg;
  assign b_to_a_full_n = ba_f_reg;
  assign bypass_indicator_n = byp_n_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  b_idle_enable_a: assert property (port_b_transfer_enable_n |-> !ab_pop && !ba_push && !ab_msg_rd && !ba_msg_wr)
    else $error("port B moved data while disabled");
  b_bus_drive_a: assert property (port_b_direction_select && !port_b_output_enable_n |=> port_b_data_oe)
    else $error("port B bus not driven in read with enable low");
  b_bus_float_a: assert property (!port_b_direction_select || port_b_output_enable_n |=> !port_b_data_oe)
    else $error("port B bus driven while it should float");
  ab_empty_flag_a: assert property (!bypass_reg && !$past(bypass_reg) |-> a_to_b_empty_n == (ab_cnt_reg != '0))
    else $error("A-to-B empty flag disagrees with count");
  ab_empty_block_a: assert property (ab_cnt_reg == '0 |-> !ab_pop)
    else $error("read from empty A-to-B queue");
  ab_msg_read_a: assert property (ab_msg_rd |=> !a_to_b_empty_n && a_to_b_full_n)
    else $error("A-to-B message flags not released after port B read");
  ab_msg_wait_a: assert property (bypass_reg && ab_msg_wr |=> a_to_b_empty_n && !a_to_b_full_n)
    else $error("A-to-B message flags not set after write");
  ab_almost_empty_a: assert property (##1 a_to_b_almost_empty_n == ($past(ab_cnt_next) > $past(pae_ab_reg)))
    else $error("A-to-B almost-empty wrong");
  ba_almost_full_a: assert property (##1 b_to_a_almost_full_n == ($past(ba_cnt_next) <= DEPTH_C - $past(paf_ba_reg)))
    else $error("B-to-A almost-full wrong");
  ab_full_block_a: assert property (ab_cnt_reg == DEPTH_C |-> !ab_push)
    else $error("write into full A-to-B queue");
  ba_empty_block_a: assert property (ba_cnt_reg == '0 |-> !ba_pop)
    else $error("read from empty B-to-A queue");
  ba_msg_read_a: assert property (ba_msg_rd |=> !b_to_a_empty_n && b_to_a_full_n)
    else $error("B-to-A message flags not released after port A read");
  ba_almost_empty_a: assert property (##1 b_to_a_almost_empty_n == ($past(ba_cnt_next) > $past(pae_ba_reg)))
    else $error("B-to-A almost-empty wrong");
  ba_full_block_a: assert property (ba_cnt_reg == DEPTH_C |-> !ba_push)
    else $error("write into full B-to-A queue");
  bypass_flag_a: assert property (##1 bypass_indicator_n == !$past(bypass_reg))
    else $error("bypass indicator does not follow mode");
  select_gate_a: assert property (port_a_select_n |-> !ab_push && !ba_pop && !ab_msg_wr && !ba_msg_rd)
    else $error("port A moved data while deselected");

  fill_ab_c: cover property (ab_push ##1 !a_to_b_full_n);
  drain_ab_c: cover property (ab_pop ##1 !a_to_b_empty_n);
  byp_trip_c: cover property (ab_msg_wr ##[1:8] ab_msg_rd);
  af_ba_c: cover property ($fell(b_to_a_almost_full_n));

endmodule : bififo_port_b_flags

// ===== testbench/port_b_host_model.sv
// Port B host model: an outside controller on the device's port B.
// Assumes the device clock is shared; the bench calls xfer hierarchically.
module port_b_host_model (
  input wire logic clk,
  input wire logic [17:0] data_out,
  output logic dir,
  output logic en_n,
  output logic oe_n,
  output logic [17:0] drive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] last;

  initial
  begin
    dir = 1'b1;
    en_n = 1'b1;
    oe_n = 1'b1;
    drive = 18'h3ffff;
    last = 18'h00000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One port B cycle; released bus shows the inverse of the word after a write, the last written word after a read
  task automatic xfer(input logic rd, input logic en, input logic oe, input logic [17:0] d,
                      output logic [17:0] q);
    @(posedge clk);
    dir <= rd;
    en_n <= ~en;
    oe_n <= ~oe;
    drive <= rd ? ~last : d;
    last <= rd ? last : d;
    @(posedge clk);
    en_n <= 1'b1;
    oe_n <= 1'b1;
    drive <= rd ? last : ~d;
    #1 q = data_out;
  endtask : xfer
endmodule : port_b_host_model

// ===== testbench/bidir_fifo_port_b_and_flags_tb.sv
// Self-checking bench for the port B and flag block.
// Assumes one clock for both ports; port A driven here, port B by the host model.
module bidir_fifo_port_b_and_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEPTH = 256;
  logic clk, reset_n, a_sel_n, a_wstb, a_rstb;
  logic [2:0] a_addr;
  logic [17:0] a_wdata, a_rdata, b_out, b_drive, b_bus, q;
  logic b_dir, b_en_n, b_oe_n, b_oe, ab_e, ab_ae, ab_af, ab_f, ba_e, ba_ae, ba_af, ba_f, byp_n;
  int miscompares, n_tests;

  assign b_bus = b_oe ? b_out : b_drive;

  bififo_port_b_flags #(.DEPTH(DEPTH), .WIDTH(18)) bififo_port_b_flags_inst (
    .clk(clk), .reset_n(reset_n), .port_a_select_n(a_sel_n), .port_a_resource_addr(a_addr),
    .port_a_write_strobe(a_wstb), .port_a_read_strobe(a_rstb), .port_a_write_data(a_wdata),
    .port_a_read_data(a_rdata), .port_b_direction_select(b_dir), .port_b_transfer_enable_n(b_en_n),
    .port_b_output_enable_n(b_oe_n), .port_b_data_in(b_bus), .port_b_data_out(b_out),
    .port_b_data_oe(b_oe), .a_to_b_empty_n(ab_e), .a_to_b_almost_empty_n(ab_ae),
    .a_to_b_almost_full_n(ab_af), .a_to_b_full_n(ab_f), .b_to_a_empty_n(ba_e),
    .b_to_a_almost_empty_n(ba_ae), .b_to_a_almost_full_n(ba_af), .b_to_a_full_n(ba_f),
    .bypass_indicator_n(byp_n));

  port_b_host_model host (.clk(clk), .data_out(b_out), .dir(b_dir), .en_n(b_en_n),
    .oe_n(b_oe_n), .drive(b_drive));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic flags(input logic e, ae, af, f, input int n, aeo, afo);
    chk("empty", 18'(e), 18'(n > 0));
    chk("almost_empty", 18'(ae), 18'(n > aeo));
    chk("almost_full", 18'(af), 18'(n <= DEPTH - afo));
    chk("full", 18'(f), 18'(n < DEPTH));
  endtask : flags

  // Port A access: one strobe cycle, read data taken in the following cycle
  task automatic a_acc(input logic sel, rd, input logic [2:0] addr, input logic [17:0] d,
                       output logic [17:0] r);
    @(posedge clk);
    a_sel_n <= ~sel;
    a_addr <= addr;
    a_wstb <= ~rd;
    a_rstb <= rd;
    a_wdata <= d;
    @(posedge clk);
    a_sel_n <= 1'b1;
    a_wstb <= 1'b0;
    a_rstb <= 1'b0;
    #1 r = a_rdata;
  endtask : a_acc

  task automatic do_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    flags(ab_e, ab_ae, ab_af, ab_f, 0, 8, 8);
    flags(ba_e, ba_ae, ba_af, ba_f, 0, 8, 8);
    chk("bypass_n", 18'(byp_n), 18'h00001);
  endtask : do_reset

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(50 * 12000);
    miscompares++;
    print_verdict;
  end

  initial
  begin
    clk = 1'b0;
    // Low from time zero so no edge ever meets unreset state
    reset_n = 1'b0;
    a_sel_n = 1'b1;
    a_wstb = 1'b0;
    a_rstb = 1'b0;
    a_addr = 3'h0;
    a_wdata = 18'h00000;
    miscompares = 0;
    n_tests = 0;
    do_reset;
    a_acc(1'b1, 1'b1, 3'h7, 18'h00000, q);
    chk("status", q & 18'h000ff, 18'h00033);
    a_acc(1'b0, 1'b0, 3'h0, 18'h00001, q);
    chk("deselected", 18'(ab_e), 18'h00000);
    a_acc(1'b1, 1'b0, 3'h2, 18'h00004, q);
    a_acc(1'b1, 1'b0, 3'h5, 18'h00010, q);
    a_acc(1'b1, 1'b1, 3'h5, 18'h00000, q);
    chk("paf_ba_off", q, 18'h00010);
    for (int i = 1; i <= DEPTH + 1; i++)
    begin
      a_acc(1'b1, 1'b0, 3'h0, 18'h2c000 ^ 18'(i), q);
      flags(ab_e, ab_ae, ab_af, ab_f, (i > DEPTH) ? DEPTH : i, 4, 8);
    end
    host.xfer(1'b1, 1'b0, 1'b1, 18'h00000, q);
    chk("idle_read", q, 18'h00000);
    flags(ab_e, ab_ae, ab_af, ab_f, DEPTH, 4, 8);
    for (int i = 1; i <= DEPTH; i++)
    begin
      host.xfer(1'b1, 1'b1, 1'b1, 18'h00000, q);
      chk("b_read", q, 18'h2c000 ^ 18'(i));
      chk("b_oe", 18'(b_oe), 18'h00001);
      flags(ab_e, ab_ae, ab_af, ab_f, DEPTH - i, 4, 8);
    end
    host.xfer(1'b1, 1'b1, 1'b0, 18'h00000, q);
    chk("empty_read", q, 18'h2c000 ^ 18'(DEPTH));
    chk("b_oe_off", 18'(b_oe), 18'h00000);
    for (int i = 1; i <= DEPTH + 1; i++)
    begin
      host.xfer(1'b0, 1'b1, 1'b0, 18'h13000 ^ 18'(i), q);
      chk("b_oe_wr", 18'(b_oe), 18'h00000);
      flags(ba_e, ba_ae, ba_af, ba_f, (i > DEPTH) ? DEPTH : i, 8, 16);
    end
    for (int i = 1; i <= DEPTH + 1; i++)
    begin
      a_acc(1'b1, 1'b1, 3'h0, 18'h00000, q);
      chk("a_read", q, (i > DEPTH) ? 18'h00000 : 18'h13000 ^ 18'(i));
      flags(ba_e, ba_ae, ba_af, ba_f, (i > DEPTH) ? 0 : DEPTH - i, 8, 16);
    end
    a_acc(1'b1, 1'b0, 3'h6, 18'h00001, q);
    // Indicator follows the mode bit one edge later
    @(posedge clk);
    #1 chk("bypass_on", 18'(byp_n), 18'h00000);
    a_acc(1'b1, 1'b0, 3'h1, 18'h2a5a5, q);
    a_acc(1'b1, 1'b0, 3'h1, 18'h11111, q);
    chk("ab_msg_e", 18'(ab_e), 18'h00001);
    chk("ab_msg_f", 18'(ab_f), 18'h00000);
    host.xfer(1'b1, 1'b1, 1'b1, 18'h00000, q);
    chk("ab_msg", q, 18'h2a5a5);
    chk("ab_msg_e2", 18'(ab_e), 18'h00000);
    chk("ab_msg_f2", 18'(ab_f), 18'h00001);
    host.xfer(1'b0, 1'b1, 1'b0, 18'h15a5a, q);
    chk("ba_msg_e", 18'(ba_e), 18'h00001);
    chk("ba_msg_f", 18'(ba_f), 18'h00000);
    a_acc(1'b1, 1'b1, 3'h1, 18'h00000, q);
    chk("ba_msg", q, 18'h15a5a);
    chk("ba_msg_e2", 18'(ba_e), 18'h00000);
    chk("ba_msg_f2", 18'(ba_f), 18'h00001);
    a_acc(1'b1, 1'b0, 3'h6, 18'h00000, q);
    @(posedge clk);
    #1 chk("bypass_off", 18'(byp_n), 18'h00001);
    for (int i = 0; i < 12; i++)
      a_acc(1'b1, 1'b0, 3'h0, 18'(i), q);
    flags(ab_e, ab_ae, ab_af, ab_f, 12, 4, 8);
    do_reset;
    a_acc(1'b1, 1'b1, 3'h2, 18'h00000, q);
    chk("pae_ab_default", q, 18'h00008);
    print_verdict;
  end
endmodule : bidir_fifo_port_b_and_flags_tb
